// file: hdl/mode_ctrl_pkg.sv
// shared constants and types for the operating mode controller
package mode_ctrl_pkg;
   // mode codes, high-order select pin first
   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'h0,
      MODE_WAKE_TX  = 2'h1,
      MODE_WAKE_RX  = 2'h2,
      MODE_SLEEP    = 2'h3
   } op_mode_t;

   typedef enum logic [2:0] {
      ST_SELFCHECK = 3'h0,
      ST_RUN       = 3'h1,
      ST_SETTLE    = 3'h2,
      ST_RECONFIG  = 3'h3
   } ctrl_state_t;

   localparam int unsigned CLK_HZ        = 200000000;
   localparam int unsigned SETTLE_US     = 1000;     // 1 ms mode switch delay
   localparam int unsigned SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1000000);
   localparam int unsigned SELFCHECK_CYCLES_DEF = 1000;
   localparam int unsigned RECONFIG_CYCLES_DEF  = 1000;
   localparam int unsigned CNT_W         = 24;
   localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   // permission word {tx, preamble, rx}: bit positions and per-mode words
   localparam int unsigned PERM_TX_BIT  = 2;
   localparam int unsigned PERM_PRE_BIT = 1;
   localparam int unsigned PERM_RX_BIT  = 0;
   localparam logic [2:0]  PERM_NORMAL  = 3'h5;
   localparam logic [2:0]  PERM_WAKE_TX = 3'h7;
   localparam logic [2:0]  PERM_WAKE_RX = 3'h1;
   localparam logic [2:0]  PERM_NONE    = 3'h0;
endpackage

// file: hdl/sel_sync.sv
// two flip-flop synchroniser for the mode select pins
`timescale 1ns/1ps
`default_nettype none
module sel_sync (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] pins,
   output logic      [1:0] pins_sync
);
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   logic [1:0] meta_d;
   logic [1:0] sync_d;

   // next values: first stage feeds only the second
   always_comb begin
      meta_d = pins;
      sync_d = meta_q;
   end

   // register both stages
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pins_sync = sync_q;
endmodule
`default_nettype wire

// file: hdl/delay_timer.sv
// down counter that pulses done when a loaded count runs out
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
   input  wire logic                             clk,
   input  wire logic                             rstn,
   input  wire logic                             load,
   input  wire logic [mode_ctrl_pkg::CNT_W-1:0] count,
   output logic                                  running,
   output logic                                  done
);
   logic [mode_ctrl_pkg::CNT_W-1:0] cnt_q;
   logic [mode_ctrl_pkg::CNT_W-1:0] cnt_d;
   logic                            done_q;
   logic                            done_d;

   // load wins over counting; done pulses on the last count
   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (load) begin
         cnt_d = count;
      end else if (cnt_q != mode_ctrl_pkg::CNT_ZERO) begin
         cnt_d = cnt_q - mode_ctrl_pkg::CNT_ONE;
         if (cnt_q == mode_ctrl_pkg::CNT_ONE) begin
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= mode_ctrl_pkg::CNT_ZERO;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign running = (cnt_q != mode_ctrl_pkg::CNT_ZERO);
   assign done    = done_q;
endmodule
`default_nettype wire

// file: hdl/mode_switch_ctrl.sv
// operating mode switch controller with busy status and mode permissions
// Notes on behaviour
// - select pin levels choose the operating mode
// - idle change takes effect after 1 ms
// - pending air transmit defers mode change
// - serial output in progress defers change
// - change acted on only while status high
// - streaming input postpones select pin sampling
// - sleep request finishes receive and send first
// - sleep entered within 1 ms after send
// - any change completes within 1 ms idle
// - mode 0 sends serial input over air
// - mode 0 receives and forwards to serial
// - mode 1 adds wake-up preamble to sends
// - mode 1 receives like mode 0
// - mode 2 keeps air transmission off
// - mode 2 accepts only wake-up frames
// - mode 3 neither transmits nor receives
// - leaving sleep reconfigures, status low meanwhile
// - pins 00,01,10,11 map modes 0 to 3
// - status low whenever any busy condition holds
`timescale 1ns/1ps
`default_nettype none
module mode_switch_ctrl #(
   parameter int unsigned SELFCHECK_CYCLES = mode_ctrl_pkg::SELFCHECK_CYCLES_DEF,
   parameter int unsigned RECONFIG_CYCLES  = mode_ctrl_pkg::RECONFIG_CYCLES_DEF,
   parameter int unsigned SETTLE_CYC       = mode_ctrl_pkg::SETTLE_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       mode_select_low,
   input  wire logic       mode_select_high,
   input  wire logic       tx_pending,
   input  wire logic       serial_in_active,
   input  wire logic       serial_out_busy,
   input  wire logic       rx_frame_valid,
   input  wire logic       rx_frame_wake,
   output logic      [1:0] op_mode,
   output logic            status_idle,
   output logic            air_tx_enable,
   output logic            wake_preamble_en,
   output logic            air_rx_enable,
   output logic            rx_forward,
   output logic            reconfig_active
);
   logic [1:0]                        sel_sync;
   logic                              tmr_load;
   logic [mode_ctrl_pkg::CNT_W-1:0]   tmr_count;
   logic                              tmr_running;
   logic                              tmr_done;
   logic                              busy;

   // decoded request terms
   logic                       busy_air;
   logic                       busy_serial;
   logic                       change_req;
   mode_ctrl_pkg::op_mode_t    sel_mode;

   // sequencer, status, permission and forward state
   mode_ctrl_pkg::ctrl_state_t state_q;
   mode_ctrl_pkg::ctrl_state_t state_d;
   mode_ctrl_pkg::op_mode_t    mode_q;
   mode_ctrl_pkg::op_mode_t    mode_d;
   mode_ctrl_pkg::op_mode_t    target_q;
   mode_ctrl_pkg::op_mode_t    target_d;
   logic                       idle_q;
   logic                       idle_d;
   logic                       tx_en_q;
   logic                       tx_en_d;
   logic                       pre_en_q;
   logic                       pre_en_d;
   logic                       rx_en_q;
   logic                       rx_en_d;
   logic                       fwd_q;
   logic                       fwd_d;
   logic                       cfg_q;
   logic                       cfg_d;

   // permissions per mode: {tx, preamble, rx}
   // sleep and any unknown code get no permission at all
   function automatic logic [2:0] mode_perm(input mode_ctrl_pkg::op_mode_t m);
      case (m)
         mode_ctrl_pkg::MODE_NORMAL:  mode_perm = mode_ctrl_pkg::PERM_NORMAL;
         mode_ctrl_pkg::MODE_WAKE_TX: mode_perm = mode_ctrl_pkg::PERM_WAKE_TX;
         mode_ctrl_pkg::MODE_WAKE_RX: mode_perm = mode_ctrl_pkg::PERM_WAKE_RX;
         default:                     mode_perm = mode_ctrl_pkg::PERM_NONE;
      endcase
   endfunction

   // transmit allowed in a mode
   function automatic logic tx_allowed(input mode_ctrl_pkg::op_mode_t m);
      logic [2:0] p;
      p          = mode_perm(m);
      tx_allowed = p[mode_ctrl_pkg::PERM_TX_BIT];
   endfunction

   // wake preamble added in a mode
   function automatic logic pre_allowed(input mode_ctrl_pkg::op_mode_t m);
      logic [2:0] p;
      p           = mode_perm(m);
      pre_allowed = p[mode_ctrl_pkg::PERM_PRE_BIT];
   endfunction

   // receiver on in a mode
   function automatic logic rx_allowed(input mode_ctrl_pkg::op_mode_t m);
      logic [2:0] p;
      p          = mode_perm(m);
      rx_allowed = p[mode_ctrl_pkg::PERM_RX_BIT];
   endfunction

   // a received frame is handed on; wake receive wants the wake mark
   function automatic logic frame_taken(input mode_ctrl_pkg::op_mode_t m,
                                        input logic                    wake);
      frame_taken = rx_allowed(m) && (m != mode_ctrl_pkg::MODE_WAKE_RX || wake);
   endfunction

   // pin synchroniser
   // each pin passes two flops, so a level changing close to a clock edge
   // cannot reach the compare below while still metastable
   sel_sync u_sync (
      .clk       (clk),
      .rstn      (rstn),
      .pins      ({mode_select_high, mode_select_low}),
      .pins_sync (sel_sync)
   );

   // settle, self-check and reconfiguration share one down counter,
   // since only one of them runs at a time
   delay_timer u_tmr (
      .clk     (clk),
      .rstn    (rstn),
      .load    (tmr_load),
      .count   (tmr_count),
      .running (tmr_running),
      .done    (tmr_done)
   );

   assign busy_air    = tx_pending;
   assign busy_serial = serial_in_active | serial_out_busy;
   // any busy condition pulls status low
   assign busy        = busy_air | busy_serial;

   assign change_req  = !busy && (sel_mode != mode_q);

   assign sel_mode    = mode_ctrl_pkg::op_mode_t'(sel_sync);

   // mode sequencing: pins are compared only in RUN with nothing busy;
   // busy during the settle time drops back to RUN, so the pins are
   // sampled afresh once the pending data has drained
   always_comb begin
      state_d   = state_q;
      mode_d    = mode_q;
      target_d  = target_q;
      cfg_d     = 1'b0;
      tmr_load  = 1'b0;
      tmr_count = mode_ctrl_pkg::CNT_ZERO;
      case (state_q)
         // power-on check holds configuration until the timer ends
         mode_ctrl_pkg::ST_SELFCHECK: begin
            cfg_d = 1'b1;
            if (tmr_done) begin
               mode_d  = sel_mode;
               state_d = mode_ctrl_pkg::ST_RUN;
               cfg_d   = 1'b0;
            end
         end
         // normal operation, watching for a new pin pair
         mode_ctrl_pkg::ST_RUN: begin
            if (change_req) begin
               target_d  = sel_mode;
               tmr_load  = 1'b1;
               tmr_count = SETTLE_CYC[mode_ctrl_pkg::CNT_W-1:0];
               state_d   = mode_ctrl_pkg::ST_SETTLE;
            end
         end
         // settle timer running toward the target mode
         mode_ctrl_pkg::ST_SETTLE: begin
            if (busy) begin
               state_d = mode_ctrl_pkg::ST_RUN;
            end else if (tmr_done) begin
               mode_d = target_q;
               if (mode_q == mode_ctrl_pkg::MODE_SLEEP) begin
                  tmr_load  = 1'b1;
                  tmr_count = RECONFIG_CYCLES[mode_ctrl_pkg::CNT_W-1:0];
                  state_d   = mode_ctrl_pkg::ST_RECONFIG;
                  cfg_d     = 1'b1;
               end else begin
                  state_d = mode_ctrl_pkg::ST_RUN;
               end
            end
         end
         // parameters reloaded after sleep
         mode_ctrl_pkg::ST_RECONFIG: begin
            cfg_d = 1'b1;
            if (tmr_done) begin
               state_d = mode_ctrl_pkg::ST_RUN;
               cfg_d   = 1'b0;
            end
         end
         // unused codes fall back to self-check
         default: begin
            state_d = mode_ctrl_pkg::ST_SELFCHECK;
         end
      endcase
      // start the self-check timer once after reset
      if (state_q == mode_ctrl_pkg::ST_SELFCHECK && !tmr_running && !tmr_done) begin
         tmr_load  = 1'b1;
         tmr_count = SELFCHECK_CYCLES[mode_ctrl_pkg::CNT_W-1:0];
      end
   end

   // sequencer registers; reset starts in self-check with the
   // configuration flag up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q  <= mode_ctrl_pkg::ST_SELFCHECK;
         mode_q   <= mode_ctrl_pkg::MODE_NORMAL;
         target_q <= mode_ctrl_pkg::MODE_NORMAL;
         cfg_q    <= 1'b1;
      end else begin
         state_q  <= state_d;
         mode_q   <= mode_d;
         target_q <= target_d;
         cfg_q    <= cfg_d;
      end
   end

   // status high only when nothing busy
   // and no configuration is running
   always_comb begin
      idle_d = !busy && !cfg_d && (state_d != mode_ctrl_pkg::ST_SELFCHECK);
   end

   // status register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_q <= 1'b0;
      end else begin
         idle_q <= idle_d;
      end
   end

   // permissions follow the next mode so they switch with op_mode;
   // configuration masks all of them
   always_comb begin
      tx_en_d  = tx_allowed(mode_d) && !cfg_d;
      pre_en_d = pre_allowed(mode_d) && !cfg_d;
      rx_en_d  = rx_allowed(mode_d) && !cfg_d;
   end

   // permission registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_en_q  <= 1'b0;
         pre_en_q <= 1'b0;
         rx_en_q  <= 1'b0;
      end else begin
         tx_en_q  <= tx_en_d;
         pre_en_q <= pre_en_d;
         rx_en_q  <= rx_en_d;
      end
   end

   // a frame is judged by the mode in force while it is present, so a
   // frame on the edge where the receiver turns off is still passed on
   always_comb begin
      fwd_d = rx_frame_valid && rx_en_q && frame_taken(mode_q, rx_frame_wake);
   end

   // forward register, one cycle after the frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fwd_q <= 1'b0;
      end else begin
         fwd_q <= fwd_d;
      end
   end

   // every output comes straight from its register; status resets low
   // so the host sees a rising edge once self-check ends
   assign op_mode          = mode_q;
   assign status_idle      = idle_q;
   assign air_tx_enable    = tx_en_q;
   assign wake_preamble_en = pre_en_q;
   assign air_rx_enable    = rx_en_q;
   assign rx_forward       = fwd_q;
   assign reconfig_active  = cfg_q;
endmodule
`default_nettype wire

// file: bench/mode_switch_sva.sv
// assertion checker on the mode switch controller ports
`timescale 1ns/1ps
`default_nettype none
module mode_switch_sva (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       mode_select_low,
   input wire logic       mode_select_high,
   input wire logic       tx_pending,
   input wire logic       serial_in_active,
   input wire logic       serial_out_busy,
   input wire logic       rx_frame_valid,
   input wire logic       rx_frame_wake,
   input wire logic [1:0] op_mode,
   input wire logic       status_idle,
   input wire logic       air_tx_enable,
   input wire logic       wake_preamble_en,
   input wire logic       air_rx_enable,
   input wire logic       rx_forward,
   input wire logic       reconfig_active
);
   // any data activity and the raw pin pair
   wire logic       busy = tx_pending | serial_in_active | serial_out_busy;
   wire logic [1:0] pins = {mode_select_high, mode_select_low};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_tx_by_mode: assert property (status_idle |-> air_tx_enable == (op_mode < 2'h2))
      else $error("tx enable wrong for mode");
   a_preamble_mode: assert property (status_idle |-> wake_preamble_en == (op_mode == 2'h1))
      else $error("preamble enable wrong for mode");
   a_rx_by_mode: assert property (status_idle |-> air_rx_enable == (op_mode != 2'h3))
      else $error("rx enable wrong for mode");
   a_busy_shown: assert property (busy |=> !status_idle)
      else $error("status idle while busy");
   a_reconfig_low: assert property (reconfig_active |-> !status_idle)
      else $error("status idle during reconfig");
   a_busy_holds: assert property (busy [*2] |=> $stable(op_mode))
      else $error("mode changed while busy");
   a_frame_fwd: assert property (rx_frame_valid |=> rx_forward == ($past(air_rx_enable) &&
      ($past(op_mode) != 2'h2 || $past(rx_frame_wake)))) else $error("frame forward wrong");
   a_no_stray_fwd: assert property (!rx_frame_valid |=> !rx_forward)
      else $error("forward without frame");
   a_mode_from_pins: assert property ($changed(op_mode) |-> $past(pins, 8) == op_mode)
      else $error("mode not from settled pins");
   c_sleep: cover property ($changed(op_mode) && op_mode == 2'h3);
   c_fwd: cover property (rx_frame_valid ##1 rx_forward);
   c_reconf: cover property ($fell(reconfig_active));
endmodule
`default_nettype wire

// file: bench/host_model.sv
// host model driving the select pins once status has stood high
`timescale 1ns/1ps
`default_nettype none
module host_model #(
   parameter int unsigned HOLD = 4
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] want,
   input  wire logic       urgent,
   input  wire logic       status_idle,
   output logic            sel_low,
   output logic            sel_high
);
   int unsigned cnt_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 0;
         {sel_high, sel_low} <= 2'h0;
      end else begin
         cnt_q <= status_idle ? cnt_q + 1 : 0;
         // static levels, urgent skips the wait
         if (urgent || cnt_q >= HOLD)
            {sel_high, sel_low} <= want;
      end
   end
endmodule
`default_nettype wire

// file: bench/mode_switch_ctrl_tb.sv
// self-checking bench for the mode switch controller
`timescale 1ns/1ps
`default_nettype none
module mode_switch_ctrl_tb;
   localparam int SETTLE = 20;
   logic       clk, rstn, sel_low, sel_high, urgent, status_idle, rx_forward;
   logic       tx_pending, serial_in_active, serial_out_busy, rx_frame_valid, rx_frame_wake;
   logic       air_tx_enable, wake_preamble_en, air_rx_enable, reconfig_active;
   logic [1:0] want, op_mode;
   int         mismatches, comparisons, cycles;
   mode_switch_ctrl #(.SELFCHECK_CYCLES(10), .RECONFIG_CYCLES(10), .SETTLE_CYC(SETTLE))
      u_mode_switch_ctrl (
      .clk, .rstn, .mode_select_low(sel_low), .mode_select_high(sel_high), .tx_pending,
      .serial_in_active, .serial_out_busy, .rx_frame_valid, .rx_frame_wake, .op_mode,
      .status_idle, .air_tx_enable, .wake_preamble_en, .air_rx_enable, .rx_forward,
      .reconfig_active);
   host_model u_host_model (.clk, .rstn, .want, .urgent, .status_idle, .sel_low, .sel_high);
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task automatic finish_test();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_mode(input logic [1:0] m, input int lim, output int n);
      n = 0;
      while (op_mode !== m && n < lim) begin
         tick(1);
         n++;
      end
   endtask
   task automatic wait_idle();
      for (int n = 0; status_idle !== 1'b1 && n < 100; n++) tick(1);
      chk({1'b0, status_idle}, 2'h1, "idle wait");
   endtask
   // one received frame, forward checked the cycle after
   task automatic frame(input logic wake, input logic exp);
      rx_frame_valid = 1;
      rx_frame_wake = wake;
      tick(1);
      rx_frame_valid = 0;
      chk({1'b0, rx_forward}, {1'b0, exp}, "forward");
      tick(1);
   endtask
   // walk every mode through an idle host and check permissions
   task automatic t_modes();
      logic [1:0] seq [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      int n;
      foreach (seq[i]) begin
         want = seq[i];
         wait_mode(seq[i], 60, n);
         chk(op_mode, seq[i], "mode");
         chk({1'(n >= SETTLE), 1'(n <= SETTLE + 10)}, 2'h3, "settle delay");
         tick(2);
         if (seq[i] == 2'h0) chk({reconfig_active, status_idle}, 2'h2, "reconfig");
         wait_idle();
         chk({air_tx_enable, wake_preamble_en}, {seq[i] < 2'h2, seq[i] == 2'h1}, "tx");
         chk({air_rx_enable, reconfig_active}, {seq[i] != 2'h3, 1'b0}, "rx");
         frame(1'b0, seq[i] < 2'h2);
         frame(1'b1, seq[i] != 2'h3);
      end
   endtask
   // change pins while busy, then release and time the switch
   task automatic t_defer(input logic [2:0] b, input logic [1:0] m);
      int n;
      {tx_pending, serial_in_active, serial_out_busy} = b;
      urgent = 1;
      want = m;
      tick(3 * SETTLE);
      chk(op_mode, 2'h0, "deferred");
      chk({1'b0, status_idle}, 2'h0, "busy shown");
      {tx_pending, serial_in_active, serial_out_busy} = 3'h0;
      wait_mode(m, 60, n);
      chk(op_mode, m, "after busy");
      chk({1'b0, 1'(n <= SETTLE + 10)}, 2'h1, "late switch");
      urgent = 0;
      want = 2'h0;
      wait_mode(2'h0, 100, n);
      chk(op_mode, 2'h0, "back to normal");
      wait_idle();
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      {rstn, urgent, want, tx_pending, serial_in_active, serial_out_busy} = 0;
      {rx_frame_valid, rx_frame_wake, mismatches, comparisons, cycles} = 0;
      tick(10);
      rstn = 1;
      wait_idle();
      t_modes();
      t_defer(3'h4, 2'h1);
      t_defer(3'h1, 2'h3);
      t_defer(3'h2, 2'h2);
      finish_test();
   end
endmodule
bind mode_switch_ctrl mode_switch_sva u_mode_switch_sva (.clk, .rstn, .mode_select_low,
   .mode_select_high, .tx_pending, .serial_in_active, .serial_out_busy, .rx_frame_valid,
   .rx_frame_wake, .op_mode, .status_idle, .air_tx_enable, .wake_preamble_en, .air_rx_enable,
   .rx_forward, .reconfig_active);
`default_nettype wire
